// >>> ghj_pkg.sv
package ghj_pkg;

   // Word indexes; byte address is four times the index
   localparam logic [7:0] IDX_H_LATCH  = 8'h20;
   localparam logic [7:0] IDX_H_INPUT  = 8'h21;
   localparam logic [7:0] IDX_H_DIR    = 8'h22;
   localparam logic [7:0] IDX_H_DRIVE  = 8'h23;
   localparam logic [7:0] IDX_H_PULL   = 8'h24;
   localparam logic [7:0] IDX_H_POL    = 8'h25;
   localparam logic [7:0] IDX_H_IEN    = 8'h26;
   localparam logic [7:0] IDX_H_FLAGS  = 8'h27;
   localparam logic [7:0] IDX_J_LATCH  = 8'h28;
   localparam logic [7:0] IDX_J_INPUT  = 8'h29;
   localparam logic [7:0] IDX_J_DIR    = 8'h2a;
   localparam logic [7:0] IDX_J_DRIVE  = 8'h2b;
   localparam logic [7:0] IDX_J_PULL   = 8'h2c;
   localparam logic [7:0] IDX_J_POL    = 8'h2d;
   localparam logic [7:0] IDX_J_IEN    = 8'h2e;
   localparam logic [7:0] IDX_J_FLAGS  = 8'h2f;

   // Reset values
   localparam logic [7:0] RST_ZERO     = 8'h00;
   localparam logic [7:0] RST_H_PULL   = 8'h00;
   localparam logic [7:0] RST_J_PULL   = 8'hc3;

   // Port J implemented positions 7:6 and 1:0
   localparam logic [7:0] J_IMPL_MASK  = 8'hc3;
   // Port H pins that the serial-peripheral unit can own
   localparam logic [7:0] H_SPI_MASK   = 8'h0f;

   // Routing control fields
   localparam int unsigned ROUTE_CAN1_LSB  = 0;
   localparam int unsigned ROUTE_CAN2_LSB  = 2;
   localparam int unsigned ROUTE_SPI_H_BIT = 5;
   localparam logic [1:0]  ROUTE_CAN2_ON_J = 2'h0;
   localparam logic [1:0]  ROUTE_CAN1_ON_J = 2'h3;

   // Port J pin positions used by the peripherals
   localparam int unsigned PIN_J_SEVEN = 7;
   localparam int unsigned PIN_J_SIX   = 6;

   // Pad controls for one 8-bit port
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
      logic [7:0] reduced;
      logic [7:0] pull_up;
      logic [7:0] pull_down;
   } ghj_pad_t;

   // Software-written configuration of one port
   typedef struct packed {
      logic [7:0] latch;
      logic [7:0] dir;
      logic [7:0] drive;
      logic [7:0] pull;
      logic [7:0] pol;
      logic [7:0] ien;
   } ghj_port_t;

   typedef enum logic [3:0] {
      ST_IDLE    = 4'b0001,
      ST_WRITE   = 4'b0010,
      ST_RD_WAIT = 4'b0100,
      ST_RD_DONE = 4'b1000
   } ghj_bus_state_t;

endpackage

// >>> ghj_gpio_ports.sv
`timescale 1ns/1ns
// Operation
// RULE1: Data read: latch if output, else pin
// RULE2: Input register always reads pins, read-only
// RULE3: Direction 1 output, 0 input, unless owned
// RULE4: Reads may lag direction change two cycles
// RULE5: Enabled SPI overrides GPIO on port H
// RULE6: Reduced drive bit acts only on outputs
// RULE7: Port H pull only on inputs, reset off
// RULE8: Polarity 1 rising/pull-down, 0 falling/pull-up
// RULE9: Enable masks flag without blocking its set
// RULE10: Active edge sets the pin's flag
// RULE11: Write 1 clears flag, 0 no effect
// RULE12: Request when flag and enable both set
// RULE13: Port J only implements bits 7:6, 1:0
// RULE14: J priority: CAN2, I2C, CAN1, GPIO
// RULE15: I2C owner makes SDA/SCL open-drain
// RULE16: CAN2 forces pin 7 out, 6 in
// RULE17: Routed CAN1 overrides GPIO on port J
// RULE18: J pull on input/open-drain, reset pull-up
// RULE19: J polarity 0 pulls up for I2C too
// RULE20: Routing control is an input
// RULE21: Pins synchronised before edge detection
// RULE22: One request per port: OR of enabled flags
module ghj_gpio_ports (
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic              hready,
   input  wire logic [31:0]       hwdata,
   output logic      [31:0]       hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   input  wire logic [7:0]        pin_h_in,
   output ghj_pkg::ghj_pad_t      pad_h,
   input  wire logic [7:0]        pin_j_in,
   output ghj_pkg::ghj_pad_t      pad_j,
   input  wire logic [7:0]        module_routing_control,
   input  wire logic              spi_enable,
   input  wire logic [3:0]        spi_out,
   input  wire logic [3:0]        spi_oe,
   output logic      [3:0]        spi_pin_in,
   input  wire logic              second_can_enable,
   input  wire logic              second_can_transmit,
   output logic                   second_can_receive,
   input  wire logic              first_can_enable,
   input  wire logic              first_can_transmit,
   output logic                   first_can_receive,
   input  wire logic              i2c_enable,
   input  wire logic              i2c_scl_drive_low,
   input  wire logic              i2c_sda_drive_low,
   output logic                   i2c_scl_in,
   output logic                   i2c_sda_in,
   output logic                   irq_h,
   output logic                   irq_j
);

   ghj_pkg::ghj_bus_state_t state;
   ghj_pkg::ghj_bus_state_t next_state;
   ghj_pkg::ghj_port_t      cfg_h;
   ghj_pkg::ghj_port_t      cfg_j;
   logic [7:0]              addr_q;
   logic [7:0]              flags_h;
   logic [7:0]              flags_j;
   logic [7:0]              next_flags_h;
   logic [7:0]              next_flags_j;
   logic [7:0]              h_s1;
   logic [7:0]              h_s2;
   logic [7:0]              h_prev;
   logic [7:0]              j_s1;
   logic [7:0]              j_s2;
   logic [7:0]              j_prev;
   logic [2:0]              sync_fill;
   logic [7:0]              edge_h;
   logic [7:0]              edge_j;
   logic [7:0]              rd_mux;
   logic [7:0]              wdata;
   logic [7:0]              spi_own;
   logic [7:0]              od_j;
   logic [7:0]              pull_act_h;
   logic [7:0]              pull_act_j;
   logic                    take;
   logic                    wr_en;
   logic                    can2_own;
   logic                    i2c_own;
   logic                    can1_own;

   // Active-edge detect per pin, polarity selected
   function automatic logic [7:0] ghj_edge(input logic [7:0] now,
                                           input logic [7:0] prev,
                                           input logic [7:0] pol);
      return (pol & now & ~prev) | (~pol & ~now & prev);
   endfunction

   // Write-one-to-clear merge; a new edge wins over the clear
   function automatic logic [7:0] ghj_flag_next(input logic [7:0] cur,
                                                input logic [7:0] clr,
                                                input logic [7:0] set);
      return (cur & ~clr) | set;
   endfunction

   // Data register view: latch for outputs, pin for inputs
   function automatic logic [7:0] ghj_data_view(input logic [7:0] dir,
                                                input logic [7:0] latch,
                                                input logic [7:0] pin);
      return (dir & latch) | (~dir & pin);
   endfunction

   // Two-stage pin synchronisers plus one history stage
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         h_s1   <= ghj_pkg::RST_ZERO;
         h_s2   <= ghj_pkg::RST_ZERO;
         h_prev <= ghj_pkg::RST_ZERO;
         j_s1   <= ghj_pkg::RST_ZERO;
         j_s2   <= ghj_pkg::RST_ZERO;
         j_prev <= ghj_pkg::RST_ZERO;
         sync_fill <= 3'b000;
      end else begin
         h_s1   <= pin_h_in;                     // [RULE21]
         h_s2   <= h_s1;                         // [RULE4]
         h_prev <= h_s2;
         j_s1   <= pin_j_in;                     // [RULE21]
         j_s2   <= j_s1;                         // [RULE4]
         j_prev <= j_s2;
         sync_fill <= {sync_fill[1:0], 1'b1};     // [RULE21]
      end
   end

   // Edge detection only looks past the second stage; held off until
   // the history stage holds a real level, so reset gives no false edge
   assign edge_h = ghj_edge(h_s2, h_prev, cfg_h.pol)
                   & {8{sync_fill[2]}};                        // [RULE10]
   assign edge_j = ghj_edge(j_s2, j_prev, cfg_j.pol)
                   & {8{sync_fill[2]}} & ghj_pkg::J_IMPL_MASK; // [RULE13]

   // Bus front end: address phase taken when the bus is ready
   assign take      = hsel & hready & htrans[1];
   assign wr_en     = (state == ghj_pkg::ST_WRITE);
   assign wdata     = hwdata[7:0];
   assign hreadyout = (state != ghj_pkg::ST_RD_WAIT);
   assign hresp     = 1'b0;

   // Reads take one wait state so a preceding write is visible
   always_comb begin
      next_state = ghj_pkg::ST_IDLE;
      unique case (state)
         ghj_pkg::ST_IDLE,
         ghj_pkg::ST_WRITE,
         ghj_pkg::ST_RD_DONE: begin
            if (take) begin
               next_state = hwrite ? ghj_pkg::ST_WRITE
                                   : ghj_pkg::ST_RD_WAIT;
            end
         end
         ghj_pkg::ST_RD_WAIT: begin
            next_state = ghj_pkg::ST_RD_DONE;
         end
         default: begin
            next_state = ghj_pkg::ST_IDLE;
         end
      endcase
   end

   // Bus state and captured word index
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state  <= ghj_pkg::ST_IDLE;
         addr_q <= ghj_pkg::RST_ZERO;
      end else begin
         state <= next_state;
         if (take) begin
            addr_q <= haddr[9:2];
         end
      end
   end

   // Read multiplexer; unmapped words read zero
   always_comb begin
      rd_mux = ghj_pkg::RST_ZERO;
      unique case (addr_q)
         ghj_pkg::IDX_H_LATCH: rd_mux = ghj_data_view(cfg_h.dir,
                                  cfg_h.latch, h_s2);          // [RULE1]
         ghj_pkg::IDX_H_INPUT: rd_mux = h_s2;                  // [RULE2]
         ghj_pkg::IDX_H_DIR:   rd_mux = cfg_h.dir;
         ghj_pkg::IDX_H_DRIVE: rd_mux = cfg_h.drive;
         ghj_pkg::IDX_H_PULL:  rd_mux = cfg_h.pull;
         ghj_pkg::IDX_H_POL:   rd_mux = cfg_h.pol;
         ghj_pkg::IDX_H_IEN:   rd_mux = cfg_h.ien;
         ghj_pkg::IDX_H_FLAGS: rd_mux = flags_h;
         ghj_pkg::IDX_J_LATCH: rd_mux = ghj_data_view(cfg_j.dir,
                                  cfg_j.latch, j_s2)
                                  & ghj_pkg::J_IMPL_MASK;      // [RULE1]
         ghj_pkg::IDX_J_INPUT: rd_mux = j_s2
                                  & ghj_pkg::J_IMPL_MASK;      // [RULE2]
         ghj_pkg::IDX_J_DIR:   rd_mux = cfg_j.dir;
         ghj_pkg::IDX_J_DRIVE: rd_mux = cfg_j.drive;
         ghj_pkg::IDX_J_PULL:  rd_mux = cfg_j.pull;
         ghj_pkg::IDX_J_POL:   rd_mux = cfg_j.pol;
         ghj_pkg::IDX_J_IEN:   rd_mux = cfg_j.ien;
         ghj_pkg::IDX_J_FLAGS: rd_mux = flags_j;
         default:              rd_mux = ghj_pkg::RST_ZERO;
      endcase
   end

   // Read data captured in the wait cycle, held until the next read
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         hrdata <= 32'h0000_0000;
      end else if (state == ghj_pkg::ST_RD_WAIT) begin
         hrdata <= {24'h0000_00, rd_mux};
      end
   end

   // Port H configuration; input register writes fall through
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cfg_h <= '{ghj_pkg::RST_ZERO, ghj_pkg::RST_ZERO,
                    ghj_pkg::RST_ZERO, ghj_pkg::RST_H_PULL,    // [RULE7]
                    ghj_pkg::RST_ZERO, ghj_pkg::RST_ZERO};
      end else if (wr_en) begin
         unique case (addr_q)
            ghj_pkg::IDX_H_LATCH: cfg_h.latch <= wdata;
            ghj_pkg::IDX_H_DIR:   cfg_h.dir   <= wdata;         // [RULE3]
            ghj_pkg::IDX_H_DRIVE: cfg_h.drive <= wdata;
            ghj_pkg::IDX_H_PULL:  cfg_h.pull  <= wdata;
            ghj_pkg::IDX_H_POL:   cfg_h.pol   <= wdata;
            ghj_pkg::IDX_H_IEN:   cfg_h.ien   <= wdata;
            default: begin
            end
         endcase
      end
   end

   // Port J configuration; unimplemented bits stay zero
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cfg_j <= '{ghj_pkg::RST_ZERO, ghj_pkg::RST_ZERO,
                    ghj_pkg::RST_ZERO, ghj_pkg::RST_J_PULL,    // [RULE18]
                    ghj_pkg::RST_ZERO, ghj_pkg::RST_ZERO};
      end else if (wr_en) begin
         unique case (addr_q)
            ghj_pkg::IDX_J_LATCH: cfg_j.latch <= wdata & ghj_pkg::J_IMPL_MASK;
            ghj_pkg::IDX_J_DIR:   cfg_j.dir   <= wdata & ghj_pkg::J_IMPL_MASK;
            ghj_pkg::IDX_J_DRIVE: cfg_j.drive <= wdata & ghj_pkg::J_IMPL_MASK;
            ghj_pkg::IDX_J_PULL:  cfg_j.pull  <= wdata & ghj_pkg::J_IMPL_MASK;
            ghj_pkg::IDX_J_POL:   cfg_j.pol   <= wdata & ghj_pkg::J_IMPL_MASK;
            ghj_pkg::IDX_J_IEN:   cfg_j.ien   <= wdata
                                  & ghj_pkg::J_IMPL_MASK;      // [RULE13]
            default: begin
            end
         endcase
      end
   end

   // Flag updates: set by edges, cleared by writing ones
   always_comb begin
      next_flags_h = ghj_flag_next(flags_h,
         (wr_en && addr_q == ghj_pkg::IDX_H_FLAGS) ? wdata
                                                   : ghj_pkg::RST_ZERO,
         edge_h);                                              // [RULE11]
      next_flags_j = ghj_flag_next(flags_j,
         (wr_en && addr_q == ghj_pkg::IDX_J_FLAGS) ? wdata
                                                   : ghj_pkg::RST_ZERO,
         edge_j) & ghj_pkg::J_IMPL_MASK;                       // [RULE13]
   end

   // Flags set regardless of the enable bits
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         flags_h <= ghj_pkg::RST_ZERO;
         flags_j <= ghj_pkg::RST_ZERO;
      end else begin
         flags_h <= next_flags_h;                     // [RULE9] [RULE10]
         flags_j <= next_flags_j;                     // [RULE9] [RULE10]
      end
   end

   // Enables only gate the request, never the flag
   assign irq_h = |(flags_h & cfg_h.ien);             // [RULE12] [RULE22]
   assign irq_j = |(flags_j & cfg_j.ien);             // [RULE12] [RULE22]

   // Ownership decode from routing control and unit enables
   assign spi_own  = (spi_enable
                      && module_routing_control[ghj_pkg::ROUTE_SPI_H_BIT])
                     ? ghj_pkg::H_SPI_MASK : ghj_pkg::RST_ZERO; // [RULE20]
   assign can2_own = second_can_enable
                     && module_routing_control[ghj_pkg::ROUTE_CAN2_LSB +: 2]
                        == ghj_pkg::ROUTE_CAN2_ON_J;           // [RULE14]
   assign i2c_own  = i2c_enable && !can2_own;                  // [RULE14]
   assign can1_own = first_can_enable && !can2_own && !i2c_own
                     && module_routing_control[ghj_pkg::ROUTE_CAN1_LSB +: 2]
                        == ghj_pkg::ROUTE_CAN1_ON_J;           // [RULE17]

   // Port H pads: SPI pins bypass latch and direction
   always_comb begin
      pad_h.out = (cfg_h.latch & ~spi_own)
                  | ({4'h0, spi_out} & spi_own);               // [RULE5]
      pad_h.oe  = (cfg_h.dir & ~spi_own)
                  | ({4'h0, spi_oe} & spi_own);          // [RULE3] [RULE5]
      pad_h.reduced   = cfg_h.drive & pad_h.oe;                // [RULE6]
      pull_act_h      = cfg_h.pull & ~pad_h.oe;                // [RULE7]
      pad_h.pull_up   = pull_act_h & ~cfg_h.pol;               // [RULE8]
      pad_h.pull_down = pull_act_h & cfg_h.pol;                // [RULE8]
   end

   // Port J pads: fixed priority on pins 7 and 6
   always_comb begin
      pad_j.out = cfg_j.latch & ghj_pkg::J_IMPL_MASK;
      pad_j.oe  = cfg_j.dir & ghj_pkg::J_IMPL_MASK;            // [RULE3]
      od_j      = ghj_pkg::RST_ZERO;
      if (can2_own) begin
         pad_j.out[ghj_pkg::PIN_J_SEVEN] = second_can_transmit;
         pad_j.oe[ghj_pkg::PIN_J_SEVEN]  = 1'b1;               // [RULE16]
         pad_j.out[ghj_pkg::PIN_J_SIX]   = 1'b0;
         pad_j.oe[ghj_pkg::PIN_J_SIX]    = 1'b0;               // [RULE16]
      end else if (i2c_own) begin
         // Open drain: drive low or release, never drive high
         pad_j.out[ghj_pkg::PIN_J_SEVEN] = 1'b0;
         pad_j.oe[ghj_pkg::PIN_J_SEVEN]  = i2c_scl_drive_low;  // [RULE15]
         pad_j.out[ghj_pkg::PIN_J_SIX]   = 1'b0;
         pad_j.oe[ghj_pkg::PIN_J_SIX]    = i2c_sda_drive_low;  // [RULE15]
         od_j[ghj_pkg::PIN_J_SEVEN]      = 1'b1;
         od_j[ghj_pkg::PIN_J_SIX]        = 1'b1;
      end else if (can1_own) begin
         pad_j.out[ghj_pkg::PIN_J_SEVEN] = first_can_transmit;
         pad_j.oe[ghj_pkg::PIN_J_SEVEN]  = 1'b1;               // [RULE17]
         pad_j.out[ghj_pkg::PIN_J_SIX]   = 1'b0;
         pad_j.oe[ghj_pkg::PIN_J_SIX]    = 1'b0;
      end
      pad_j.reduced = cfg_j.drive & pad_j.oe;                  // [RULE6]
      // Pull stays on for open-drain so released lines float high
      pull_act_j      = cfg_j.pull & (~pad_j.oe | od_j);       // [RULE18]
      pad_j.pull_up   = pull_act_j & ~cfg_j.pol;         // [RULE8] [RULE19]
      pad_j.pull_down = pull_act_j & cfg_j.pol & ~pad_j.oe & ~od_j;
   end

   // Receive paths come straight from the synchroniser outputs
   assign spi_pin_in         = h_s2[3:0];
   assign second_can_receive = j_s2[ghj_pkg::PIN_J_SIX];
   assign first_can_receive  = j_s2[ghj_pkg::PIN_J_SIX];
   assign i2c_scl_in         = j_s2[ghj_pkg::PIN_J_SEVEN];
   assign i2c_sda_in         = j_s2[ghj_pkg::PIN_J_SIX];

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   // Read transfer: one wait cycle, then data with ready
   sequence s_read_take;
      take && !hwrite;
   endsequence
   sequence s_read_answer;
      !hreadyout ##1 hreadyout;
   endsequence

   a_read_wait_state: assert property (                        // [RULE1]
      s_read_take |=> s_read_answer)
      else $error("read answer timing wrong");

   a_read_data_view: assert property (                         // [RULE1]
      (state == ghj_pkg::ST_RD_WAIT && addr_q == ghj_pkg::IDX_H_LATCH)
      |=> hrdata[7:0] == (($past(cfg_h.dir) & $past(cfg_h.latch))
                          | (~$past(cfg_h.dir) & $past(h_s2))))
      else $error("port H data read mismatch");

   a_input_reg_pins: assert property (                         // [RULE2]
      (state == ghj_pkg::ST_RD_WAIT && addr_q == ghj_pkg::IDX_J_INPUT)
      |=> hrdata[7:0] == ($past(j_s2) & ghj_pkg::J_IMPL_MASK))
      else $error("port J input read mismatch");

   a_pin_sync_lag: assert property (                           // [RULE21]
      $rose(pin_h_in[0]) ##1 pin_h_in[0] ##1 pin_h_in[0]
      |-> h_s2[0])
      else $error("pin not seen after two stages");

   a_flag_edge_set: assert property (                          // [RULE10]
      edge_h[0] |=> flags_h[0])
      else $error("edge did not set flag");

   a_flag_w1c_clear: assert property (                         // [RULE11]
      (wr_en && addr_q == ghj_pkg::IDX_H_FLAGS && edge_h == 8'h00)
      |=> (flags_h & $past(wdata)) == 8'h00
          && (flags_h & ~$past(wdata)) == ($past(flags_h) & ~$past(wdata)))
      else $error("flag clear behaviour wrong");

   a_irq_enabled_flag: assert property (                 // [RULE12] [RULE22]
      (edge_j[1] && cfg_j.ien[1]) |=> irq_j)
      else $error("enabled flag raised no request");

   a_j_unimplemented: assert property (                        // [RULE13]
      (flags_j & ~ghj_pkg::J_IMPL_MASK) == 8'h00
      && (cfg_j.dir & ~ghj_pkg::J_IMPL_MASK) == 8'h00)
      else $error("port J unimplemented bit set");

   a_spi_override: assert property (                           // [RULE5]
      spi_own[0] |-> pad_h.oe[0] == spi_oe[0]
                     && pad_h.out[0] == spi_out[0])
      else $error("SPI did not own port H pin");

   a_can2_forced_dir: assert property (                        // [RULE16]
      can2_own |-> pad_j.oe[7] && !pad_j.oe[6]
                   && pad_j.out[7] == second_can_transmit)
      else $error("second CAN direction not forced");

   a_i2c_open_drain: assert property (                         // [RULE15]
      (i2c_enable && !can2_own) |-> pad_j.out[7:6] == 2'b00
                                    && pad_j.oe[6] == i2c_sda_drive_low)
      else $error("I2C pins not open drain");

   a_pull_h_input: assert property (                           // [RULE7]
      ((pad_h.pull_up | pad_h.pull_down) & pad_h.oe) == 8'h00)
      else $error("port H pull on an output");

endmodule

// >>> ghj_pin_model.sv
`timescale 1ns/1ns
// Pins of one port: pad drivers, outside drivers and pull devices
module ghj_pin_model (
   input  wire logic              clk_sys,
   input  wire ghj_pkg::ghj_pad_t pad,
   input  wire logic [7:0]        ext_val,
   input  wire logic [7:0]        ext_en,
   output logic      [7:0]        pin
);
   logic [7:0] last = 8'h00;

   // Floating pins toggle so a stale level never reads as valid
   always @(posedge clk_sys) begin
      last <= pin;
   end

   // Two drivers on one wire: low wins, as on a shorted output
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pad.oe[i] || ext_en[i]) begin
            pin[i] = (~pad.oe[i] | pad.out[i]) & (~ext_en[i] | ext_val[i]);
         end else if (pad.pull_up[i]) begin
            pin[i] = 1'b1;
         end else if (pad.pull_down[i]) begin
            pin[i] = 1'b0;
         end else begin
            pin[i] = ~last[i];
         end
      end
   end
endmodule

// >>> ghj_gpio_ports_test.sv
`timescale 1ns/1ns
module ghj_gpio_ports_test;
   logic              clk_sys = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0]       haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0]        htrans = 2'b00;
   logic [2:0]        hsize = 3'b010;
   logic              hreadyout, hresp, hready, irq_h, irq_j;
   logic [7:0]        pin_h_in, pin_j_in, ext_h = 8'hff, ext_en_j = 8'h03;
   logic [7:0]        module_routing_control = 8'h00;
   logic [3:0]        spi_out = 4'h0, spi_oe = 4'h0, spi_pin_in;
   logic              spi_enable = 1'b0, i2c_enable = 1'b0;
   logic              second_can_enable = 1'b0, second_can_transmit = 1'b1;
   logic              first_can_enable = 1'b0, first_can_transmit = 1'b0;
   logic              i2c_scl_drive_low = 1'b1, i2c_sda_drive_low = 1'b0;
   logic              second_can_receive, first_can_receive;
   logic              i2c_scl_in, i2c_sda_in;
   ghj_pkg::ghj_pad_t pad_h, pad_j;
   int                n_mismatch = 0, samples_checked = 0;

   // Single slave: its ready is the bus ready
   assign hready = hreadyout;
   always #2 clk_sys = ~clk_sys;

   ghj_gpio_ports dut_u (.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .pin_h_in,
      .pad_h, .pin_j_in, .pad_j, .module_routing_control, .spi_enable,
      .spi_out, .spi_oe, .spi_pin_in, .second_can_enable,
      .second_can_transmit, .second_can_receive, .first_can_enable,
      .first_can_transmit, .first_can_receive, .i2c_enable,
      .i2c_scl_drive_low, .i2c_sda_drive_low, .i2c_scl_in, .i2c_sda_in,
      .irq_h, .irq_j);
   ghj_pin_model pins_h_u (.clk_sys(clk_sys), .pad(pad_h), .ext_val(ext_h),
      .ext_en(8'hff), .pin(pin_h_in));
   ghj_pin_model pins_j_u (.clk_sys(clk_sys), .pad(pad_j), .ext_val(8'hff),
      .ext_en(ext_en_j), .pin(pin_j_in));

   task automatic stop_test();
      $display("compared %0d mismatched %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   // Bounded wait for hready sampled high at a rising edge
   task automatic wait_ready();
      int n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         n_mismatch++;
         stop_test();
      end
   endtask

   // One single word transfer: address phase, then data phase
   task automatic bus(input logic wr_en, input logic [7:0] idx,
                      input logic [31:0] wd);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr_en;
      haddr <= {22'h0, idx, 2'b00};
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask

   task automatic rd_chk(input string what, input logic [7:0] idx,
                         input logic [31:0] exp);
      bus(1'b0, idx, 32'h0);
      check(what, rd, exp);
   endtask

   // Pads are looked at mid-cycle, well past the sync stages
   task automatic settle();
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask

   task automatic jcase(input logic [7:0] route, input logic en2, iic, en1,
                        input logic [1:0] oe, input logic o7,
                        input logic [1:0] pu);
      @(posedge clk_sys);
      module_routing_control <= route;
      second_can_enable <= en2;
      i2c_enable <= iic;
      first_can_enable <= en1;
      settle();
      check("j oe", pad_j.oe[7:6], oe);
      check("j out7", pad_j.out[7], o7);
      check("j pull", pad_j.pull_up[7:6], pu);
   endtask

   initial begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      check("j pull reset", pad_j.pull_up, 8'hc3);
      check("h pads reset", pad_h.pull_up | pad_h.pull_down, 8'h0);
      for (int i = 2; i < 8; i++) begin
         rd_chk("h reset", 8'h20 + 8'(i), 32'h0);
         rd_chk("j reset", 8'h28 + 8'(i),
                (i == 4) ? 32'hc3 : 32'h0);
      end
      for (int i = 2; i < 7; i++) begin
         bus(1'b1, 8'h20 + 8'(i), 32'hff);
         bus(1'b1, 8'h28 + 8'(i), 32'hff);
         rd_chk("h cfg", 8'h20 + 8'(i), 32'hff);
         rd_chk("j cfg", 8'h28 + 8'(i), 32'hc3);
      end
      settle();
      check("h oe", pad_h.oe, 8'hff);
      check("h reduced", pad_h.reduced, 8'hff);
      check("h out pull", pad_h.pull_down, 8'h0);
      bus(1'b1, ghj_pkg::IDX_H_DIR, 32'h0);
      settle();
      check("h in reduced", pad_h.reduced, 8'h0);
      check("h pull down", pad_h.pull_down, 8'hff);
      for (int i = 2; i < 7; i++) begin
         bus(1'b1, 8'h20 + 8'(i), 32'h0);
         bus(1'b1, 8'h28 + 8'(i), 32'h0);
      end
      bus(1'b1, 8'h10, 32'hff);
      rd_chk("unmapped", 8'h10, 32'h0);
      // Output pins shorted low from outside: data shows latch, input pins
      bus(1'b1, ghj_pkg::IDX_H_LATCH, 32'h5a);
      bus(1'b1, ghj_pkg::IDX_H_DIR, 32'h0f);
      ext_h <= 8'h3c;
      settle();
      rd_chk("h data", ghj_pkg::IDX_H_LATCH, 32'h3a);
      bus(1'b1, ghj_pkg::IDX_H_INPUT, 32'h0);
      rd_chk("h input", ghj_pkg::IDX_H_INPUT, 32'h38);
      module_routing_control <= 8'h20;
      spi_enable <= 1'b1;
      spi_oe <= 4'h3;
      spi_out <= 4'h1;
      settle();
      check("spi oe", pad_h.oe, 8'h03);
      check("spi out", pad_h.out[1:0], 2'h1);
      check("spi in", spi_pin_in, 4'hc);
      @(posedge clk_sys);
      spi_enable <= 1'b0;
      bus(1'b1, ghj_pkg::IDX_H_DIR, 32'h0);
      bus(1'b1, ghj_pkg::IDX_H_POL, 32'h02);
      bus(1'b1, ghj_pkg::IDX_H_IEN, 32'h01);
      ext_h <= 8'hff;
      settle();
      bus(1'b1, ghj_pkg::IDX_H_FLAGS, 32'hff);
      rd_chk("flags clear", ghj_pkg::IDX_H_FLAGS, 32'h0);
      ext_h <= 8'hfc;
      settle();
      rd_chk("fall flag", ghj_pkg::IDX_H_FLAGS, 32'h01);
      check("irq on", irq_h, 1'b1);
      ext_h <= 8'hfe;
      settle();
      rd_chk("rise flag", ghj_pkg::IDX_H_FLAGS, 32'h03);
      bus(1'b1, ghj_pkg::IDX_H_FLAGS, 32'h02);
      rd_chk("w1c", ghj_pkg::IDX_H_FLAGS, 32'h01);
      bus(1'b1, ghj_pkg::IDX_H_FLAGS, 32'h01);
      rd_chk("flags gone", ghj_pkg::IDX_H_FLAGS, 32'h0);
      check("irq off", irq_h, 1'b0);
      check("irq j masked", irq_j, 1'b0);
      // Port J ownership, one case for each owner
      bus(1'b1, ghj_pkg::IDX_J_LATCH, 32'h80);
      bus(1'b1, ghj_pkg::IDX_J_DIR, 32'hc3);
      bus(1'b1, ghj_pkg::IDX_J_PULL, 32'hc3);
      jcase(8'h00, 1'b0, 1'b0, 1'b0, 2'b11, 1'b1, 2'b00);
      jcase(8'h0f, 1'b0, 1'b0, 1'b1, 2'b10, 1'b0, 2'b01);
      jcase(8'h0f, 1'b0, 1'b1, 1'b1, 2'b10, 1'b0, 2'b11);
      check("i2c in", {i2c_scl_in, i2c_sda_in}, 2'b01);
      jcase(8'h03, 1'b1, 1'b1, 1'b1, 2'b10, 1'b1, 2'b01);
      check("can rx", {second_can_receive, first_can_receive}, 2'b11);
      jcase(8'h03, 1'b0, 1'b0, 1'b0, 2'b11, 1'b1, 2'b00);
      stop_test();
   end
endmodule
